// file: inc/clb_pkg.sv
// Constants for the charger option low byte register bank.
// Assumes a serial engine outside that turns host bus frames into byte
// read and write strobes on the ref_clk domain.
// Functional notes
// - Latch control set holds the comparator output tripped after it goes low.
// - With latching in the hot profile, trip flag stays one until host read clears.
// - Host toggles latch control to release a latched comparator output.
// - Undervoltage disable bit zero keeps protection on; one turns it off.
// - Learn bit lets battery discharge with converter off; host writes zero to return.
// - Input current monitor gain: zero gives 20x, one gives 40x.
// - Battery current monitor gain: zero gives 8x, one 16x; default one.
// - Linear pre-charge clamps current at 384 mA, or 2A for one cell 3.0-3.6V.
// - Linear pre-charge off turns battery switch fully on, regulates from max voltage.
// - Device clears regulation enable bit whenever it turns regulation off itself.
// - Charging block bit zero allows charging while charge settings are valid, one blocks it.
// - Auto-off enabled and battery-present pin falling clears regulation enable.
package clb_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CLB_OPT_LOW_ADDR  = 8'h00;
  localparam logic [7:0] CLB_OPT_LOW_RESET = 8'h0e;
  localparam logic [7:0] CLB_UNMAPPED_DATA = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CLB_CMP_LATCH_BIT   = 7;
  localparam int CLB_UVP_DISABLE_BIT = 6;
  localparam int CLB_LEARN_BIT       = 5;
  localparam int CLB_IIN_GAIN_BIT    = 4;
  localparam int CLB_BAT_GAIN_BIT    = 3;
  localparam int CLB_LIN_PRECHG_BIT  = 2;
  localparam int CLB_IIN_REG_BIT     = 1;
  localparam int CLB_CHG_BLOCK_BIT   = 0;

  // ****************************************
  // Pre-charge clamps in mA
  // ****************************************
  localparam logic [11:0] CLB_CLAMP_LOW_MA  = 12'h180;
  localparam logic [11:0] CLB_CLAMP_HIGH_MA = 12'h7d0;

  // ****************************************
  // Synchroniser reset levels
  // ****************************************
  localparam logic [2:0] CLB_CMP_SYNC_RESET = 3'h7;
  localparam logic [2:0] CLB_BAT_SYNC_RESET = 3'h0;

  typedef struct packed {
    logic [7:0]  optReg;
    logic [2:0]  cmpSync;
    logic [2:0]  batSync;
    logic        cmpLow;
    logic        batPresent;
    logic        latched;
    logic        tripFlag;
    logic [7:0]  rdData;
    logic        cmpPin;
    logic        uvpActive;
    logic        learnActive;
    logic        converterOff;
    logic        iinGain;
    logic        batGain;
    logic [11:0] clampMa;
    logic        switchFullOn;
    logic        regulateFromMax;
    logic        chargeAllowed;
    logic        iinRegEnable;
  } clb_state_s;

endpackage

// file: design/clb_option_low.sv
// Charger option low byte: register, comparator latch, pre-charge clamp
// and the device-side control outputs derived from the byte.
// Assumes byte strobes from a serial engine on ref_clk; comparator and
// battery-present pins are asynchronous to ref_clk.
`timescale 1ns/1ps

module clb_option_low (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  input  wire logic [7:0]                  regAddr,
  input  wire logic [7:0]                  regWrData,
  output logic      [7:0]                  regRdData,
  input  wire logic                        comparatorIn,
  input  wire logic                        batteryPresentPin,
  input  wire logic                        regulationAutoOff,
  input  wire logic                        processorHotProfileLatch,
  input  wire logic                        tripStatusRead,
  input  wire logic                        oneCell,
  input  wire logic                        vbatAbove3v0,
  input  wire logic                        vbatBelow3v6,
  input  wire logic                        chargeSettingsValid,
  output logic                             comparatorOutPin,
  output logic                             compTripFlag,
  output logic                             uvpActive,
  output logic                             learnActive,
  output logic                             converterOff,
  output logic                             inputCurrentMonitorGain,
  output logic                             batteryCurrentMonitorGain,
  output logic      [11:0]                 prechargeClampMa,
  output logic                             batterySwitchFullOn,
  output logic                             regulateFromMaxVoltage,
  output logic                             chargeAllowed,
  output logic                             inputCurrentRegEnable
);
  import clb_pkg::*;

  // ****************************************
  // State
  // ****************************************
  localparam clb_state_s RESET_STATE = '{
    optReg:          CLB_OPT_LOW_RESET,
    cmpSync:         CLB_CMP_SYNC_RESET,
    batSync:         CLB_BAT_SYNC_RESET,
    cmpLow:          1'b0,
    batPresent:      1'b0,
    latched:         1'b0,
    tripFlag:        1'b0,
    rdData:          CLB_UNMAPPED_DATA,
    cmpPin:          1'b1,
    uvpActive:       ~CLB_OPT_LOW_RESET[CLB_UVP_DISABLE_BIT],
    learnActive:     CLB_OPT_LOW_RESET[CLB_LEARN_BIT],
    converterOff:    CLB_OPT_LOW_RESET[CLB_LEARN_BIT],
    iinGain:         CLB_OPT_LOW_RESET[CLB_IIN_GAIN_BIT],
    batGain:         CLB_OPT_LOW_RESET[CLB_BAT_GAIN_BIT],
    clampMa:         CLB_CLAMP_LOW_MA,
    switchFullOn:    ~CLB_OPT_LOW_RESET[CLB_LIN_PRECHG_BIT],
    regulateFromMax: ~CLB_OPT_LOW_RESET[CLB_LIN_PRECHG_BIT],
    chargeAllowed:   1'b0,
    iinRegEnable:    CLB_OPT_LOW_RESET[CLB_IIN_REG_BIT]
  };

  clb_state_s state_reg;
  clb_state_s state_next;
  logic       wrHit;
  logic       rdHit;
  logic       latchToggle;
  logic       batFall;
  logic       tripSet;

  assign wrHit       = regWrite && (regAddr == CLB_OPT_LOW_ADDR);
  assign rdHit       = regRead && (regAddr == CLB_OPT_LOW_ADDR);
  assign latchToggle = wrHit &&
                       (regWrData[CLB_CMP_LATCH_BIT] != state_reg.optReg[CLB_CMP_LATCH_BIT]);
  // Edge taken from the filtered level, so a glitch on the pin cannot fire it
  assign batFall     = state_reg.batPresent && (state_reg.batSync[1] == state_reg.batSync[2])
                       && !state_reg.batSync[2];
  assign tripSet     = state_reg.optReg[CLB_CMP_LATCH_BIT] && processorHotProfileLatch &&
                       state_reg.cmpLow;

  always_comb begin
    state_next = state_reg;

    // ****************************************
    // Pin synchronisers and agreement filter
    // ****************************************
    state_next.cmpSync = {state_reg.cmpSync[1:0], comparatorIn};
    state_next.batSync = {state_reg.batSync[1:0], batteryPresentPin};
    if (state_reg.cmpSync[1] == state_reg.cmpSync[2]) begin
      state_next.cmpLow = ~state_reg.cmpSync[2];
    end
    if (state_reg.batSync[1] == state_reg.batSync[2]) begin
      state_next.batPresent = state_reg.batSync[2];
    end

    // ****************************************
    // Register access
    // ****************************************
    // host write back
    if (wrHit) begin
      state_next.optReg = regWrData;
    end
    // auto off
    // The device clear wins over a host write in the same cycle
    if (regulationAutoOff && batFall) begin
      state_next.optReg[CLB_IIN_REG_BIT] = 1'b0;
    end
    if (rdHit) begin
      state_next.rdData = state_reg.optReg;
    end else if (regRead) begin
      state_next.rdData = CLB_UNMAPPED_DATA;
    end

    // ****************************************
    // Comparator latch
    // ****************************************
    // toggle release
    if (latchToggle || !state_next.optReg[CLB_CMP_LATCH_BIT]) begin
      state_next.latched = 1'b0;
    end else if (state_next.cmpLow) begin
      state_next.latched = 1'b1;
    end
    state_next.cmpPin = ~(state_next.cmpLow | state_next.latched);
    // sticky trip
    // A trip in the cycle of the read still sets the flag
    if (tripSet) begin
      state_next.tripFlag = 1'b1;
    end else if (tripStatusRead) begin
      state_next.tripFlag = 1'b0;
    end

    // ****************************************
    // Control outputs
    // ****************************************
    // undervoltage control
    state_next.uvpActive    = ~state_next.optReg[CLB_UVP_DISABLE_BIT];
    state_next.learnActive  = state_next.optReg[CLB_LEARN_BIT];
    state_next.converterOff = state_next.optReg[CLB_LEARN_BIT];
    state_next.iinGain      = state_next.optReg[CLB_IIN_GAIN_BIT];
    state_next.batGain      = state_next.optReg[CLB_BAT_GAIN_BIT];
    if (oneCell && vbatAbove3v0 && vbatBelow3v6) begin
      state_next.clampMa = CLB_CLAMP_HIGH_MA;
    end else begin
      state_next.clampMa = CLB_CLAMP_LOW_MA;
    end
    state_next.switchFullOn    = ~state_next.optReg[CLB_LIN_PRECHG_BIT];
    state_next.regulateFromMax = ~state_next.optReg[CLB_LIN_PRECHG_BIT];
    state_next.chargeAllowed = ~state_next.optReg[CLB_CHG_BLOCK_BIT] && chargeSettingsValid;
    state_next.iinRegEnable  = state_next.optReg[CLB_IIN_REG_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdData                 = state_reg.rdData;
  assign comparatorOutPin          = state_reg.cmpPin;
  assign compTripFlag              = state_reg.tripFlag;
  assign uvpActive                 = state_reg.uvpActive;
  assign learnActive               = state_reg.learnActive;
  assign converterOff              = state_reg.converterOff;
  assign inputCurrentMonitorGain   = state_reg.iinGain;
  assign batteryCurrentMonitorGain = state_reg.batGain;
  assign prechargeClampMa          = state_reg.clampMa;
  assign batterySwitchFullOn       = state_reg.switchFullOn;
  assign regulateFromMaxVoltage    = state_reg.regulateFromMax;
  assign chargeAllowed             = state_reg.chargeAllowed;
  assign inputCurrentRegEnable     = state_reg.iinRegEnable;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_latch_hold_low: assert property (
    (state_reg.latched && state_reg.optReg[CLB_CMP_LATCH_BIT] && !wrHit && !batFall)
      |=> !comparatorOutPin)
    else $error("latched comparator output released without toggle");

  a_trip_sticky: assert property (
    (tripSet && !tripStatusRead) ##1 !tripStatusRead[*3] |-> compTripFlag)
    else $error("trip flag dropped before host read");

  a_trip_read_clear: assert property (
    (compTripFlag && tripStatusRead && !tripSet) |=> !compTripFlag)
    else $error("trip flag not cleared by read");

  a_toggle_release: assert property (
    latchToggle |=> !state_reg.latched)
    else $error("latch toggle did not release output");

  a_uvp_follow: assert property (
    uvpActive == !state_reg.optReg[CLB_UVP_DISABLE_BIT])
    else $error("undervoltage control does not follow its bit");

  a_learn_write: assert property (
    (wrHit && !regWrData[CLB_LEARN_BIT]) |=> (!learnActive && !converterOff))
    else $error("learn mode not left after write of zero");

  a_gain_select: assert property (
    wrHit |=> (inputCurrentMonitorGain == $past(regWrData[CLB_IIN_GAIN_BIT]) &&
               batteryCurrentMonitorGain == $past(regWrData[CLB_BAT_GAIN_BIT])))
    else $error("gain select does not follow written value");

  a_clamp_value: assert property (
    ##1 prechargeClampMa == (($past(oneCell) && $past(vbatAbove3v0) && $past(vbatBelow3v6))
                             ? CLB_CLAMP_HIGH_MA : CLB_CLAMP_LOW_MA))
    else $error("pre-charge clamp value wrong");

  a_switch_full: assert property (
    (batterySwitchFullOn == regulateFromMaxVoltage) &&
    (batterySwitchFullOn == !state_reg.optReg[CLB_LIN_PRECHG_BIT]))
    else $error("battery switch state disagrees with pre-charge bit");

  a_auto_off_clear: assert property (
    (regulationAutoOff && batFall) |=> (!inputCurrentRegEnable &&
                                        !state_reg.optReg[CLB_IIN_REG_BIT]))
    else $error("auto off did not clear regulation enable");

  a_charge_block: assert property (
    chargeAllowed |-> !state_reg.optReg[CLB_CHG_BLOCK_BIT])
    else $error("charging allowed while blocked");

  a_reset_value: assert property (
    $fell(rst) |-> state_reg.optReg == CLB_OPT_LOW_RESET)
    else $error("register byte not at reset value");

  a_read_data: assert property (
    (rdHit && !$past(rst)) |=> regRdData == $past(state_reg.optReg))
    else $error("read did not return register byte");

endmodule

// file: bench/clb_host_model.sv
// Host processor model driving the byte strobe port of the option byte.
// Assumes the bench calls its tasks; all strobes move at the falling edge.
`timescale 1ns/1ps

module clb_host_model (
  input  wire logic       ref_clk,
  output logic            regWrite,
  output logic            regRead,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);
  initial begin
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    regWrite  = 1'b1;
    regAddr   = addr;
    regWrData = data;
    @(negedge ref_clk);
    regWrite  = 1'b0;
    // Idle bus shows no stale value, so a late capture is caught
    regAddr   = ~addr;
    regWrData = ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge ref_clk);
    regRead = 1'b1;
    regAddr = addr;
    @(negedge ref_clk);
    regRead = 1'b0;
    regAddr = ~addr;
    data    = regRdData;
  endtask
endmodule

// file: bench/clb_option_low_bench.sv
// Self-checking bench for the option low byte register bank.
// Assumes the host model owns the register strobes; bench drives pins.
`timescale 1ns/1ps
`define CLB_CHK(nm, e, g) samplesChecked++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", nm, e, g); failures++; end

module clb_option_low_bench;
  import clb_pkg::*;
  logic ref_clk, rst, regWrite, regRead, cmpIn, batPin, autoOff, hotLatch;
  logic tripRd, oneCell, above3, below3, setValid;
  logic [7:0]  regAddr, regWrData, regRdData, rd;
  logic        cmpPin, tripFlag, uvp, learn, convOff, iinGain, batGain;
  logic        swOn, fromMax, chgOk, iinEn;
  logic [11:0] clampMa;
  int          failures, samplesChecked, cycleCount;
  logic [7:0]  pats [4] = '{8'h00, 8'hff, 8'h55, 8'haa};

  clb_host_model host (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  clb_option_low DUT (.ref_clk(ref_clk), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .comparatorIn(cmpIn), .batteryPresentPin(batPin),
    .regulationAutoOff(autoOff), .processorHotProfileLatch(hotLatch),
    .tripStatusRead(tripRd), .oneCell(oneCell), .vbatAbove3v0(above3),
    .vbatBelow3v6(below3), .chargeSettingsValid(setValid),
    .comparatorOutPin(cmpPin), .compTripFlag(tripFlag), .uvpActive(uvp),
    .learnActive(learn), .converterOff(convOff), .inputCurrentMonitorGain(iinGain),
    .batteryCurrentMonitorGain(batGain), .prechargeClampMa(clampMa),
    .batterySwitchFullOn(swOn), .regulateFromMaxVoltage(fromMax),
    .chargeAllowed(chgOk), .inputCurrentRegEnable(iinEn));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk_all(input logic [7:0] b);
    host.read_reg(CLB_OPT_LOW_ADDR, rd);
    `CLB_CHK("readback", b, rd)
    `CLB_CHK("uvpActive", ~b[6], uvp)
    `CLB_CHK("learn", {b[5], b[5]}, {learn, convOff})
    `CLB_CHK("gains", b[4:3], {iinGain, batGain})
    `CLB_CHK("switch", {~b[2], ~b[2]}, {swOn, fromMax})
    `CLB_CHK("chargeAllowed", ~b[0] & setValid, chgOk)
    `CLB_CHK("iinEnable", b[1], iinEn)
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, cmpIn, batPin, setValid} = 4'hf;
    {autoOff, hotLatch, tripRd, oneCell, above3, below3} = 6'h00;
    failures = 0;
    samplesChecked = 0;
    waitc(4);
    rst = 1'b0;
    chk_all(CLB_OPT_LOW_RESET);
    `CLB_CHK("clampReset", CLB_CLAMP_LOW_MA, clampMa)
    $display("test reset done");
    foreach (pats[i]) begin
      host.write_reg(CLB_OPT_LOW_ADDR, pats[i]);
      chk_all(pats[i]);
    end
    setValid = 1'b0;
    chk_all(8'haa);
    host.write_reg(8'h01, 8'hff);
    host.read_reg(8'h01, rd);
    `CLB_CHK("unmapped", CLB_UNMAPPED_DATA, rd)
    chk_all(8'haa);
    $display("test fields done");
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h04);
    {oneCell, above3, below3} = 3'h7;
    waitc(2);
    `CLB_CHK("clamp2A", CLB_CLAMP_HIGH_MA, clampMa)
    {oneCell, above3, below3} = 3'h3;
    waitc(2);
    `CLB_CHK("clampMulti", CLB_CLAMP_LOW_MA, clampMa)
    {oneCell, above3, below3} = 3'h5;
    waitc(2);
    `CLB_CHK("clampLowV", CLB_CLAMP_LOW_MA, clampMa)
    $display("test clamp done");
    hotLatch = 1'b1;
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h00);
    cmpIn = 1'b0;
    waitc(8);
    `CLB_CHK("cmpFollowLow", 2'b00, {cmpPin, tripFlag})
    cmpIn = 1'b1;
    waitc(8);
    `CLB_CHK("cmpFollowHigh", 1'b1, cmpPin)
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h80);
    cmpIn = 1'b0;
    waitc(8);
    cmpIn = 1'b1;
    waitc(8);
    `CLB_CHK("cmpLatched", 2'b01, {cmpPin, tripFlag})
    tripRd = 1'b1;
    waitc(1);
    tripRd = 1'b0;
    waitc(2);
    `CLB_CHK("tripCleared", 2'b00, {cmpPin, tripFlag})
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h00);
    waitc(2);
    `CLB_CHK("cmpReleased", 1'b1, cmpPin)
    // Latch without the hot profile must not raise the trip flag
    hotLatch = 1'b0;
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h80);
    cmpIn = 1'b0;
    waitc(8);
    cmpIn = 1'b1;
    waitc(8);
    `CLB_CHK("cmpNoProfile", 2'b00, {cmpPin, tripFlag})
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h00);
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h80);
    waitc(2);
    `CLB_CHK("cmpToggled", 1'b1, cmpPin)
    $display("test comparator done");
    autoOff = 1'b1;
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h0a);
    batPin = 1'b0;
    waitc(8);
    chk_all(8'h08);
    host.write_reg(CLB_OPT_LOW_ADDR, 8'h0a);
    chk_all(8'h0a);
    batPin = 1'b1;
    waitc(8);
    autoOff = 1'b0;
    batPin = 1'b0;
    waitc(8);
    chk_all(8'h0a);
    $display("test auto off done");
    finish_test();
  end
endmodule
